/* xfer8_pkg.sv */
// Constants, types and cycle tables for the 8-bit transfer execution unit
package xfer8_pkg;
   typedef enum logic [3:0] {
      M_REG    = 4'h0, M_SADDR  = 4'h1, M_SFR    = 4'h2, M_ABS    = 4'h3,
      M_PSW    = 4'h4, M_DE     = 4'h5, M_HL     = 4'h6, M_HLBYTE = 4'h7,
      M_HLB    = 4'h8, M_HLC    = 4'h9
   } mode_e;
   typedef enum logic [3:0] {
      K_RP    = 4'h0, K_SADDRP = 4'h1, K_SFRP  = 4'h2, K_ABS16W = 4'h3,
      K_CALL  = 4'h4, K_VECT   = 4'h5, K_BIT   = 4'h6, K_BANK   = 4'h7,
      K_DISP  = 4'h8, K_SADDR  = 4'h9, K_ABS16 = 4'ha
   } opnd_kind_e;
   typedef enum logic {ST_IDLE = 1'b0, ST_EXEC = 1'b1} state_e;
   // Absolute register numbers
   localparam logic [2:0] R_X = 3'h0, R_A = 3'h1, R_C = 3'h2, R_B = 3'h3;
   localparam logic [2:0] R_E = 3'h4, R_D = 3'h5, R_L = 3'h6, R_H = 3'h7;
   // Address windows
   localparam logic [15:0] SADDR_BASE  = 16'hfe20;
   localparam logic [15:0] SFR_BASE    = 16'hff00;
   localparam logic [15:0] SFR_HOLE_LO = 16'hffd0;
   localparam logic [15:0] SFR_HOLE_HI = 16'hffdf;
   localparam logic [15:0] CALL_BASE   = 16'h0800;
   localparam logic [15:0] VECT_BASE   = 16'h0040;
   localparam logic [15:0] HSRAM_LO    = 16'hfb00;
   localparam logic [15:0] HSRAM_HI    = 16'hfeff;
   // Program status word fields
   localparam int PSW_CY = 0, PSW_RBS0 = 3, PSW_AC = 4, PSW_RBS1 = 5, PSW_Z = 6, PSW_IE = 7;
   localparam logic [7:0] PSW_RESET = 8'h02;
   localparam logic [7:0] CTL_RESET = 8'h01;
   // Register port offsets
   localparam logic [3:0] OFS_PSW = 4'h8, OFS_STAT = 4'h9, OFS_CTL = 4'ha;
   localparam int STAT_BUSY = 0, STAT_REJ = 1, CTL_EN = 0;
   // Clock cycles per form, indexed by mode
   typedef logic [3:0] cyc_t [0:9];
   localparam cyc_t CYC_COPY_HS = '{4'h2, 4'h4, 4'h5, 4'h8, 4'h5, 4'h4, 4'h4, 4'h8, 4'h6, 4'h6};
   localparam cyc_t CYC_COPY_OT = '{4'h2, 4'h5, 4'h5, 4'h9, 4'h5, 4'h5, 4'h5, 4'h9, 4'h7, 4'h7};
   localparam cyc_t CYC_SWAP_HS = '{4'h2, 4'h4, 4'h6, 4'h8, 4'h0, 4'h4, 4'h4, 4'h8, 4'h8, 4'h8};
   localparam cyc_t CYC_SWAP_OT = '{4'h2, 4'h6, 4'h6, 4'ha, 4'h0, 4'h6, 4'h6, 4'ha, 4'ha, 4'ha};
   localparam cyc_t CYC_IMM_HS  = '{4'h4, 4'h6, 4'h7, 4'h0, 4'h7, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
   localparam cyc_t CYC_IMM_OT  = '{4'h4, 4'h7, 4'h7, 4'h0, 4'h7, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
   // Instruction byte counts, indexed by mode
   typedef logic [1:0] len_t [0:9];
   localparam len_t LEN_COPY = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1};
   localparam len_t LEN_SWAP = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
   localparam len_t LEN_IMM  = '{2'h2, 2'h3, 2'h3, 2'h0, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
endpackage

/* xfer8_exec.sv */
// Execution unit for 8-bit copy and swap instructions with operand decoding
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ns
module xfer8_exec
   import xfer8_pkg::*;
#(
   parameter logic [15:0] HS_LO = HSRAM_LO,
   parameter logic [15:0] HS_HI = HSRAM_HI
) (
   input  wire logic                   MCLK,
   input  wire logic                   RESET,
   input  wire logic                   CE,
   input  wire logic                   INSN_VALID,
   output      logic                   INSN_READY,
   input  wire logic                   INSN_SWAP,
   input  wire logic                   INSN_TO_A,
   input  wire logic                   INSN_IMM,
   input  xfer8_pkg::mode_e            INSN_MODE,
   input  wire logic [2:0]             INSN_REG,
   input  wire logic [7:0]             INSN_BYTE,
   input  wire logic [15:0]            INSN_ADDR,
   output      logic                   INSN_DONE,
   output      logic                   INSN_REJECT,
   output      logic [1:0]             INSN_LEN,
   output      logic                   INT_HOLD,
   output      logic [15:0]            MEM_ADDR,
   output      logic [7:0]             MEM_WDATA,
   output      logic                   MEM_RD,
   output      logic                   MEM_WR,
   input  wire logic [7:0]             MEM_RDATA,
   input  xfer8_pkg::opnd_kind_e       OPND_KIND,
   input  wire logic [15:0]            OPND_CODE,
   output      logic [15:0]            OPND_VALUE,
   output      logic                   OPND_OK,
   input  wire logic [3:0]             REG_ADDR,
   input  wire logic [7:0]             REG_WDATA,
   input  wire logic                   REG_WR,
   input  wire logic                   REG_RD,
   output      logic [7:0]             REG_RDATA
);
   import xfer8_pkg::*;

   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   logic [7:0]  regs_reg [0:7];
   logic [7:0]  psw_reg;
   logic [7:0]  ctl_reg;
   logic        rej_reg;
   state_e      state_reg;
   logic [3:0]  cnt_reg;
   logic [3:0]  ncyc_reg;
   logic        swap_reg;
   logic        to_a_reg;
   logic        imm_reg;
   mode_e       mode_reg;
   logic [2:0]  rsel_reg;
   logic [7:0]  src_reg;
   logic [7:0]  data_reg;
   logic [15:0] addr_reg;
   logic        done_reg;
   logic        reject_reg;
   logic [1:0]  len_reg;
   logic [7:0]  rdata_reg;
   logic [15:0] ov_reg;
   logic        ok_reg;

   // Operand address and legality for the instruction offered
   wire  [15:0] hl          = {regs_reg[R_H], regs_reg[R_L]};
   wire  [15:0] de          = {regs_reg[R_D], regs_reg[R_E]};
   wire  [15:0] saddr_ea    = SADDR_BASE + {8'h00, INSN_ADDR[7:0]};
   wire  [15:0] sfr_ea      = SFR_BASE + {8'h00, INSN_ADDR[7:0]};
   logic [15:0] ea;
   always_comb begin
      unique case (INSN_MODE)
         M_SADDR:  ea = saddr_ea;
         M_SFR:    ea = sfr_ea;
         M_ABS:    ea = INSN_ADDR;
         M_DE:     ea = de;
         M_HL:     ea = hl;
         M_HLBYTE: ea = hl + {8'h00, INSN_BYTE};
         M_HLB:    ea = hl + {8'h00, regs_reg[R_B]};
         M_HLC:    ea = hl + {8'h00, regs_reg[R_C]};
         default:  ea = 16'h0000;
      endcase
   end
   wire         mem_mode    = !(INSN_MODE inside {M_REG, M_PSW});
   wire         hs          = mem_mode && (INSN_MODE != M_SFR) && in_range(ea, HS_LO, HS_HI);
   wire         sfr_hole    = (INSN_MODE == M_SFR) && in_range(sfr_ea, SFR_HOLE_LO, SFR_HOLE_HI);
   wire         imm_bad     = INSN_IMM && (INSN_SWAP || !(INSN_MODE inside {M_REG, M_SADDR, M_SFR, M_PSW}));
   wire         mode_bad    = (INSN_MODE > M_HLC) || (INSN_SWAP && INSN_MODE == M_PSW);
   wire         illegal     = imm_bad || mode_bad || sfr_hole || !ctl_reg[CTL_EN];
   wire  [3:0]  ncyc        = INSN_IMM  ? (hs ? CYC_IMM_HS[INSN_MODE]  : CYC_IMM_OT[INSN_MODE])  :
                              INSN_SWAP ? (hs ? CYC_SWAP_HS[INSN_MODE] : CYC_SWAP_OT[INSN_MODE]) :
                                          (hs ? CYC_COPY_HS[INSN_MODE] : CYC_COPY_OT[INSN_MODE]);
   wire  [1:0]  nlen        = INSN_IMM ? LEN_IMM[INSN_MODE] :
                              INSN_SWAP ? LEN_SWAP[INSN_MODE] : LEN_COPY[INSN_MODE];
   wire         idle        = (state_reg == ST_IDLE);
   wire         take        = CE && INSN_VALID && idle;
   wire         accept      = take && !illegal;
   wire         reject      = take && illegal;
   wire  [7:0]  src_val     = INSN_IMM ? INSN_BYTE : regs_reg[R_A];

   // Memory strobes of the running instruction
   wire         run_mem     = !idle && !(mode_reg inside {M_REG, M_PSW});
   wire         rd_op       = run_mem && (swap_reg || to_a_reg) && !imm_reg;
   wire         wr_op       = run_mem && (swap_reg || !to_a_reg || imm_reg);
   wire         last        = !idle && (cnt_reg == ncyc_reg - 4'h1);
   wire         psw_dest    = (mode_reg == M_PSW) && (imm_reg || !to_a_reg);

   assign INSN_READY  = idle;
   assign MEM_RD      = CE && rd_op && (cnt_reg == 4'h1);
   assign MEM_WR      = CE && wr_op && (cnt_reg == (swap_reg ? 4'h2 : 4'h1));
   assign INT_HOLD    = !idle && swap_reg;
   assign MEM_ADDR    = addr_reg;
   assign MEM_WDATA   = src_reg;
   assign INSN_DONE   = done_reg;
   assign INSN_REJECT = reject_reg;
   assign INSN_LEN    = len_reg;
   assign REG_RDATA   = rdata_reg;
   assign OPND_VALUE  = ov_reg;
   assign OPND_OK     = ok_reg;

   // Result value written on the last cycle
   wire  [7:0]  mem_byte    = (cnt_reg == 4'h2) ? MEM_RDATA : data_reg;
   logic [7:0]  op_val;
   always_comb begin
      unique case (mode_reg)
         M_REG:   op_val = regs_reg[rsel_reg];
         M_PSW:   op_val = psw_reg;
         default: op_val = mem_byte;
      endcase
   end

   // Sequencer
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         state_reg  <= ST_IDLE;
         cnt_reg    <= 4'h0;
         ncyc_reg   <= 4'h0;
         swap_reg   <= 1'b0;
         to_a_reg   <= 1'b0;
         imm_reg    <= 1'b0;
         mode_reg   <= M_REG;
         rsel_reg   <= 3'h0;
         src_reg    <= 8'h00;
         data_reg   <= 8'h00;
         addr_reg   <= 16'h0000;
         done_reg   <= 1'b0;
         reject_reg <= 1'b0;
         len_reg    <= 2'h0;
      end else if (CE) begin
         done_reg   <= last;
         reject_reg <= reject;
         if (accept) begin
            state_reg <= ST_EXEC;
            cnt_reg   <= 4'h1;
            ncyc_reg  <= ncyc;
            swap_reg  <= INSN_SWAP;
            to_a_reg  <= INSN_TO_A;
            imm_reg   <= INSN_IMM;
            mode_reg  <= INSN_MODE;
            rsel_reg  <= INSN_REG;
            src_reg   <= src_val;
            addr_reg  <= ea;
            len_reg   <= nlen;
         end else if (last) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 4'h0;
         end else if (!idle) begin
            cnt_reg   <= cnt_reg + 4'h1;
         end
         if (!idle && cnt_reg == 4'h2) begin
            data_reg <= MEM_RDATA;
         end
      end
   end

   // Register file, status word and software port
   wire         bus_wr      = CE && REG_WR && idle;
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         for (int i = 0; i < 8; i++) begin
            regs_reg[i] <= 8'h00;
         end
         psw_reg <= PSW_RESET;
         ctl_reg <= CTL_RESET;
      end else if (CE) begin
         if (last) begin
            if (swap_reg) begin
               regs_reg[R_A] <= op_val;
               if (mode_reg == M_REG) begin
                  regs_reg[rsel_reg] <= src_reg;
               end
            end else if (mode_reg == M_REG && (imm_reg || !to_a_reg)) begin
               regs_reg[rsel_reg] <= src_reg;
            end else if (to_a_reg && !imm_reg) begin
               regs_reg[R_A] <= op_val;
            end
            if (psw_dest) begin
               psw_reg <= src_reg;
            end
         end else if (bus_wr && REG_ADDR < OFS_PSW) begin
            regs_reg[REG_ADDR[2:0]] <= REG_WDATA;
         end else if (bus_wr && REG_ADDR == OFS_PSW) begin
            psw_reg <= REG_WDATA;
         end
         if (CE && REG_WR && REG_ADDR == OFS_CTL) begin
            ctl_reg <= REG_WDATA;
         end
      end
   end

   // Sticky reject flag, cleared by writing one; a new reject wins
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         rej_reg <= 1'b0;
      end else if (CE) begin
         if (reject) begin
            rej_reg <= 1'b1;
         end else if (REG_WR && REG_ADDR == OFS_STAT && REG_WDATA[STAT_REJ]) begin
            rej_reg <= 1'b0;
         end
      end
   end

   wire  [7:0]  stat_val    = {6'h00, rej_reg, !idle};
   wire  [7:0]  rd_val      = (REG_ADDR < OFS_PSW) ? regs_reg[REG_ADDR[2:0]] :
                              (REG_ADDR == OFS_PSW) ? psw_reg :
                              (REG_ADDR == OFS_STAT) ? stat_val :
                              (REG_ADDR == OFS_CTL) ? ctl_reg : 8'h00;
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         rdata_reg <= 8'h00;
      end else if (CE) begin
         rdata_reg <= REG_RD ? rd_val : 8'h00;
      end
   end

   // Stand-alone operand decoder
   wire  [15:0] pair_val    = {regs_reg[{OPND_CODE[1:0], 1'b1}], regs_reg[{OPND_CODE[1:0], 1'b0}]};
   wire  [15:0] sp_ea       = SADDR_BASE + {8'h00, OPND_CODE[7:0]};
   wire  [15:0] sf_ea       = SFR_BASE + {8'h00, OPND_CODE[7:0]};
   logic [15:0] ov;
   logic        ok;
   always_comb begin
      ov = 16'h0000;
      ok = 1'b1;
      unique case (OPND_KIND)
         K_RP:     ov = pair_val;
         K_SADDR:  ov = sp_ea;
         K_SADDRP: begin
            ov = sp_ea;
            ok = !sp_ea[0];
         end
         K_SFRP:   begin
            ov = sf_ea;
            ok = !sf_ea[0] && !in_range(sf_ea, SFR_HOLE_LO, SFR_HOLE_HI);
         end
         K_ABS16:  ov = OPND_CODE;
         K_ABS16W: begin
            ov = OPND_CODE;
            ok = !OPND_CODE[0];
         end
         K_CALL:   ov = CALL_BASE | {5'h00, OPND_CODE[10:0]};
         K_VECT:   ov = VECT_BASE + {10'h000, OPND_CODE[4:0], 1'b0};
         K_BIT:    ov = {8'h00, 8'h01 << OPND_CODE[2:0]};
         K_BANK:   ov = {14'h0000, OPND_CODE[1:0]};
         K_DISP:   ov = {{8{OPND_CODE[7]}}, OPND_CODE[7:0]};
         default:  ok = 1'b0;
      endcase
   end
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         ov_reg <= 16'h0000;
         ok_reg <= 1'b0;
      end else if (CE) begin
         ov_reg <= ok ? ov : 16'h0000;
         ok_reg <= ok;
      end
   end

   // Checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);

   chk_pair_bytes: assert property (CE && OPND_KIND == K_RP && OPND_CODE[1:0] == 2'h0 |=>
      OPND_VALUE == {$past(regs_reg[R_A]), $past(regs_reg[R_X])}) else $error("pair byte order wrong");
   chk_saddr_window: assert property (mode_reg == M_SADDR && (MEM_RD || MEM_WR) |->
      in_range(MEM_ADDR, SADDR_BASE, 16'hff1f)) else $error("short direct outside window");
   chk_sfr_hole: assert property (mode_reg == M_SFR && (MEM_RD || MEM_WR) |->
      !in_range(MEM_ADDR, SFR_HOLE_LO, SFR_HOLE_HI)) else $error("special register hole reached");
   chk_flags_kept: assert property (CE && !idle && !psw_dest |=> $stable(psw_reg)) else $error("flags changed");
   chk_psw_load: assert property (accept && INSN_IMM && INSN_MODE == M_PSW |->
      ##7 psw_reg == $past(INSN_BYTE, 7)) else $error("status word not loaded");
   chk_hlb_cycles: assert property (accept && !INSN_SWAP && INSN_MODE == M_HLB && hs |->
      !INSN_DONE [*6] ##1 INSN_DONE) else $error("copy HL+B cycle count");
   chk_swap_cycles: assert property (accept && INSN_SWAP && INSN_MODE == M_HLBYTE && !hs
      |-> ##1 (!INSN_DONE && INSN_LEN == 2'h2) [*8] ##1 !INSN_DONE ##1 INSN_DONE)
      else $error("swap HL+byte cycle count");
   chk_copy_len: assert property (accept && !INSN_SWAP && INSN_MODE inside {M_HLB, M_HLC} |->
      ##1 INSN_LEN == 2'h1)
      else $error("indexed copy length");
   chk_swap_len: assert property (accept && INSN_SWAP && INSN_MODE inside {M_HLBYTE, M_HLB} |->
      ##1 INSN_LEN == 2'h2)
      else $error("indexed swap length");
   chk_hold_span: assert property (accept && INSN_SWAP |=> INT_HOLD)
      else $error("swap started without hold");
   chk_saddrp_window: assert property (CE && OPND_KIND == K_SADDRP |=>
      !OPND_OK || in_range(OPND_VALUE, SADDR_BASE, 16'hff1f))
      else $error("short pair outside window");
   chk_call_region: assert property (CE && OPND_KIND == K_CALL |=>
      OPND_OK && in_range(OPND_VALUE, CALL_BASE, 16'h0fff))
      else $error("call region outside range");
   chk_vect_region: assert property (CE && OPND_KIND == K_VECT |=>
      in_range(OPND_VALUE, VECT_BASE, 16'h007f) && !OPND_VALUE[0])
      else $error("vector outside table");
   chk_bit_onehot: assert property (CE && OPND_KIND == K_BIT |=>
      $onehot(OPND_VALUE[7:0]) && OPND_VALUE[15:8] == 8'h00)
      else $error("bit mask not one hot");
   chk_bank_range: assert property (CE && OPND_KIND == K_BANK |=>
      OPND_VALUE <= 16'h0003)
      else $error("bank out of range");
   chk_disp_sign: assert property (CE && OPND_KIND == K_DISP |=>
      OPND_VALUE == {{8{$past(OPND_CODE[7])}}, $past(OPND_CODE[7:0])})
      else $error("displacement not sign extended");
   chk_swap_atomic: assert property (MEM_RD && swap_reg |-> INT_HOLD ##1 (MEM_WR && INT_HOLD))
      else $error("swap not held together");
   chk_reject_quiet: assert property (reject |=> idle && !MEM_RD && !MEM_WR && INSN_REJECT)
      else $error("rejected form made access");
   chk_even_pairs: assert property (CE && OPND_KIND inside {K_SADDRP, K_SFRP, K_ABS16W, K_VECT} |=>
      !(OPND_OK && OPND_VALUE[0])) else $error("odd address accepted");

   cov_swap_mem: cover property (MEM_RD && swap_reg ##1 MEM_WR);
   cov_reject: cover property (INSN_REJECT);
   cov_psw_write: cover property (last && psw_dest);
   cov_hs_copy: cover property (accept && hs && !INSN_SWAP);
   cov_reg_copy: cover property (last && mode_reg == M_REG);
endmodule

/* mem_model.sv */
// Byte-wide data memory on the far side of the execution unit
`timescale 1ns/1ns
module mem_model (
   input  wire logic        clk,
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        rd,
   input  wire logic        wr,
   output      logic [7:0]  rdata
);
   logic [7:0] ram [0:65535];
   initial begin
      rdata = 8'h00;
      for (int i = 0; i < 65536; i++) ram[i] = i[15:8] ^ i[7:0];
   end
   // Read data stand one cycle only, then turn to garbage
   always @(posedge clk) begin
      rdata <= rd ? ram[addr] : ~rdata;
      if (wr) ram[addr] <= wdata;
   end
endmodule

/* testbench.sv */
// Self-checking bench for the 8-bit transfer execution unit
`timescale 1ns/1ns
module testbench;
   import xfer8_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, valid = 1'b0, swp = 1'b0, toa = 1'b0, imm = 1'b0, rwr = 1'b0, rrd = 1'b0;
   logic        ready, done, rej, hold, mrd, mwr, ook, rj_seen, mem_seen, hold_seen;
   mode_e       mode = M_REG;
   opnd_kind_e  kind = K_RP;
   logic [2:0]  rsel = 3'h0;
   logic [7:0]  ibyte = 8'h00, rwd = 8'h00, wdat, rdat, rrdat, ev;
   logic [15:0] iaddr = 16'h0000, code = 16'h0000, maddr, oval, seen_addr, ea;
   logic [3:0]  radr = 4'h0;
   logic [1:0]  len;
   int          n_fail = 0, cmp_count = 0, cyc;
   localparam mode_e       IX_M [8] = '{M_HLB, M_HLB, M_HLC, M_HLC, M_HLBYTE, M_HLBYTE, M_HLB, M_HLB};
   localparam logic [7:0]  IX_LO [8] = '{8'h05, 8'h05, 8'h07, 8'h07, 8'h10, 8'h10, 8'h05, 8'h05};
   localparam int          IX_CYC [8] = '{6, 7, 6, 7, 8, 10, 8, 10};
   localparam opnd_kind_e  OP_K [13] = '{K_SADDR, K_SADDRP, K_SADDRP, K_SFRP, K_SFRP, K_SFRP, K_ABS16W,
                                        K_ABS16, K_CALL, K_VECT, K_BIT, K_BANK, K_DISP};
   localparam logic [15:0] OP_C [13] = '{16'h00ff, 16'h0001, 16'h00e0, 16'h0003, 16'h00d4, 16'h0002, 16'h1235,
                                        16'h1235, 16'h07ff, 16'h001f, 16'h0007, 16'h0003, 16'h0080};
   localparam logic [15:0] OP_V [13] = '{16'hff1f, 16'h0000, 16'hff00, 16'h0000, 16'h0000, 16'hff02, 16'h0000,
                                        16'h1235, 16'h0fff, 16'h007e, 16'h0080, 16'h0003, 16'hff80};
   localparam logic        OP_F [13] = '{1, 0, 1, 0, 0, 1, 0, 1, 1, 1, 1, 1, 1};

   xfer8_exec uut (.MCLK(clk), .RESET(rst), .CE(1'b1), .INSN_VALID(valid), .INSN_READY(ready), .INSN_SWAP(swp),
      .INSN_TO_A(toa), .INSN_IMM(imm), .INSN_MODE(mode), .INSN_REG(rsel), .INSN_BYTE(ibyte), .INSN_ADDR(iaddr),
      .INSN_DONE(done), .INSN_REJECT(rej), .INSN_LEN(len), .INT_HOLD(hold), .MEM_ADDR(maddr), .MEM_WDATA(wdat),
      .MEM_RD(mrd), .MEM_WR(mwr), .MEM_RDATA(rdat), .OPND_KIND(kind), .OPND_CODE(code), .OPND_VALUE(oval),
      .OPND_OK(ook), .REG_ADDR(radr), .REG_WDATA(rwd), .REG_WR(rwr), .REG_RD(rrd), .REG_RDATA(rrdat));
   mem_model far (.clk(clk), .addr(maddr), .wdata(wdat), .rd(mrd), .wr(mwr), .rdata(rdat));

   initial begin
      forever #10 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic rwrite(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      rwr <= 1'b1;
      radr <= a;
      rwd <= d;
      @(posedge clk);
      rwr <= 1'b0;
   endtask

   task automatic rread(input logic [3:0] a, input logic [7:0] exp, input string nm);
      @(posedge clk);
      rrd <= 1'b1;
      radr <= a;
      @(posedge clk);
      rrd <= 1'b0;
      #1;
      chk(nm, {8'h00, exp}, {8'h00, rrdat});
   endtask

   // Offer one instruction, then count cycles to completion or refusal
   task automatic run(input logic s, input logic t, input logic im, input mode_e m, input logic [2:0] r,
                      input logic [7:0] b, input logic [15:0] a);
      @(posedge clk);
      valid <= 1'b1;
      swp <= s;
      toa <= t;
      imm <= im;
      mode <= m;
      rsel <= r;
      ibyte <= b;
      iaddr <= a;
      @(posedge clk);
      valid <= 1'b0;
      mem_seen = 1'b0;
      hold_seen = 1'b0;
      for (cyc = 1; cyc <= 20; cyc++) begin
         #1;
         if (mrd === 1'b1 || mwr === 1'b1) begin
            mem_seen = 1'b1;
            seen_addr = maddr;
         end
         if (hold === 1'b1) hold_seen = 1'b1;
         if (done === 1'b1 || rej === 1'b1) break;
         @(posedge clk);
      end
      rj_seen = rej;
      if (cyc > 20) begin
         n_fail++;
         tally_and_finish();
      end
   endtask

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rread(4'h8, 8'h02, "psw reset");
      rread(4'ha, 8'h01, "ctl reset");
      rread(4'h9, 8'h00, "status reset");
      // Register file through copies into A
      for (int r = 0; r < 8; r++) rwrite(r[3:0], 8'h10 + r[7:0]);
      for (int r = 0; r < 8; r++) begin
         if (r == 1) continue;
         run(1'b0, 1'b1, 1'b0, M_REG, r[2:0], 8'h00, 16'h0000);
         chk("copy reg cycles", 16'd2, 16'(cyc));
         rread(4'h1, 8'h10 + r[7:0], "copy reg to a");
      end
      // Indexed forms, both speed areas
      rwrite(4'h6, 8'h00);
      rwrite(4'h3, 8'h05);
      rwrite(4'h2, 8'h07);
      rwrite(4'h8, 8'h51);
      for (int i = 0; i < 8; i++) begin
         ea = {(i % 2 == 0) ? 8'hfb : 8'h20, IX_LO[i]};
         rwrite(4'h7, ea[15:8]);
         rwrite(4'h1, 8'h5a);
         run(i >= 4, i < 2, 1'b0, IX_M[i], 3'h0, 8'h10, 16'h0000);
         chk("indexed cycles", IX_CYC[i][15:0], 16'(cyc));
         chk("indexed length", (i >= 4) ? 16'd2 : 16'd1, {14'h0, len});
         chk("indexed address", ea, seen_addr);
         chk("swap hold", {15'h0, i >= 4}, {15'h0, hold_seen});
         ev = (i < 2 || i >= 4) ? (ea[15:8] ^ ea[7:0]) : 8'h5a;
         rread(4'h1, ev, "indexed a value");
         if (i >= 2) chk("memory written", 16'h005a, {8'h00, far.ram[ea]});
      end
      rread(4'h8, 8'h51, "flags kept");
      run(1'b0, 1'b0, 1'b1, M_PSW, 3'h0, 8'h11, 16'h0000);
      chk("psw imm cycles", 16'd7, 16'(cyc));
      rread(4'h8, 8'h11, "psw from imm");
      rwrite(4'h1, 8'h40);
      run(1'b0, 1'b0, 1'b0, M_PSW, 3'h0, 8'h00, 16'h0000);
      rread(4'h8, 8'h40, "psw from a");
      run(1'b0, 1'b1, 1'b0, M_SFR, 3'h0, 8'h00, 16'h0010);
      chk("sfr address", 16'hff10, seen_addr);
      run(1'b0, 1'b1, 1'b0, M_SADDR, 3'h0, 8'h00, 16'h00ff);
      chk("saddr address", 16'hff1f, seen_addr);
      chk("saddr cycles", 16'd5, 16'(cyc));
      // Illegal forms
      run(1'b1, 1'b0, 1'b0, M_PSW, 3'h0, 8'h00, 16'h0000);
      chk("swap psw reject", 16'd1, {15'h0, rj_seen & ~mem_seen});
      run(1'b0, 1'b0, 1'b1, M_HL, 3'h0, 8'h00, 16'h0000);
      chk("imm hl reject", 16'd1, {15'h0, rj_seen & ~mem_seen});
      run(1'b0, 1'b1, 1'b0, M_SFR, 3'h0, 8'h00, 16'h00d5);
      chk("sfr hole reject", 16'd1, {15'h0, rj_seen & ~mem_seen});
      run(1'b0, 1'b1, 1'b0, mode_e'(4'hb), 3'h0, 8'h00, 16'h0000);
      chk("bad mode reject", 16'd1, {15'h0, rj_seen & ~mem_seen});
      rread(4'h9, 8'h02, "reject sticky");
      rwrite(4'h9, 8'h02);
      rread(4'h9, 8'h00, "reject cleared");
      rwrite(4'ha, 8'h00);
      run(1'b0, 1'b1, 1'b0, M_REG, 3'h0, 8'h00, 16'h0000);
      chk("disabled reject", 16'd1, {15'h0, rj_seen});
      rwrite(4'ha, 8'h01);
      // Operand decoder table
      for (int i = 0; i < 13; i++) begin
         @(posedge clk);
         kind <= OP_K[i];
         code <= OP_C[i];
         @(posedge clk);
         #1;
         chk("operand value", OP_V[i], oval);
         chk("operand ok", {15'h0, OP_F[i]}, {15'h0, ook});
      end
      @(posedge clk);
      kind <= K_RP;
      code <= 16'h0003;
      @(posedge clk);
      #1;
      chk("pointer pair", 16'h2000, oval);
      tally_and_finish();
   end
endmodule
